// ### common/sbdb_pkg.sv
// Package for the serial baud generator and data buffer block.
// Assumes a single 32-bit AHB-Lite slave port and one system clock.
package sbdb_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_DATA_BUF  = 8'h18;
  localparam logic [7:0] OFF_BAUD_SEL  = 8'h1C;
  localparam logic [7:0] OFF_STATUS    = 8'h20;

  // Reset value of the baud select register.
  localparam logic [7:0] BAUD_SEL_RESET = 8'h00;

  // Field positions inside the baud select register.
  localparam int BAUD_DIV_LSB = 0;  // Three-bit baud divisor select.
  localparam int PRESC_LSB    = 4;  // Two-bit prescale select.

  // Field positions inside the status register.
  localparam int STAT_RX_ACTIVE = 0;
  localparam int STAT_RX_FULL   = 1;
  localparam int STAT_TX_ROOM   = 2;

  // Timing counts, in receiver sampling ticks or clocks.
  localparam int TICKS_PER_BIT = 16;   // Sampling ticks per bit.
  localparam int CLK_PER_UNIT  = 4;    // 64 / 16: clocks per prescaler unit.
  localparam int START_MID     = 8;    // Slot at which the start bit is verified.
  localparam int IDLE_TICKS    = 160;  // Ten high bit times mark an idle character.
  localparam int DATA_BITS     = 8;
  localparam int FIFO_DEPTH    = 4;

  // Captured AHB-Lite address phase.
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } sbdb_phase_t;

  // Receiver states, one-hot.
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } sbdb_rx_state_t;

  // Transmitter states, one-hot.
  typedef enum logic [1:0] {
    TX_IDLE = 2'h1,
    TX_SEND = 2'h2
  } sbdb_tx_state_t;

endpackage

// ### src/sbdb_top.sv
// Serial baud generator, shared data buffer and reception-active flag,
// with a transmit FIFO, reached over AHB-Lite.
// Assumes RXD comes from outside the clock domain and HREADY is this
// slave's own HREADYOUT.
// Overview of operation
// RULE_01: The reception-active flag sets when a low is sampled in the first start-search slot.
// RULE_02: The flag clears on a rejected false start bit or on a detected idle character.
// RULE_03: The flag is read-only and never raises an interrupt.
// RULE_04: Software polls the flag before disabling the interface or stopping.
// RULE_05: Reading the data buffer gives received bits, writing it gives bits to send.
// RULE_06: Reset leaves the data buffer contents untouched.
// RULE_07: Software does no read-modify-write on the data buffer.
// RULE_08: One baud setting serves both receiver and transmitter.
// RULE_09: Prescale select 00,01,10,11 divides by 1,3,4,13.
// RULE_10: Baud divisor select n divides by two to the power n.
// RULE_11: Bit rate equals bus clock over 64 times both divisors.
// RULE_12: Reset clears both divisor selects, giving the fastest rate.
// RULE_13: A sampling tick at sixteen times the bit rate counts the search slots.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module sbdb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             REF_CLK,
  input  wire logic             RESET,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // Honest full and empty come straight from the occupancy count.
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage is not reset; only the pointers and the occupancy count are.
  always_ff @(posedge REF_CLK) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  // Pointers wrap modulo the depth.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + AW'(1);
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module sbdb_top (
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        RXD,
  output logic             TXD,
  output logic             RX_ACTIVE
);
  sbdb_pkg::sbdb_phase_t    ph_r;
  sbdb_pkg::sbdb_rx_state_t rx_st_r;
  sbdb_pkg::sbdb_tx_state_t tx_st_r;
  logic [7:0]  baud_r;
  logic [31:0] hrdata_r;
  logic [7:0]  rx_data_r;
  logic        rx_full_r;
  logic        rx_act_r;
  logic        rx_m_r;
  logic        rx_s_r;
  logic [7:0]  pre_cnt_r;
  logic [6:0]  bd_cnt_r;
  logic        tick16;
  logic [3:0]  slot_r;
  logic [3:0]  bit_r;
  logic [7:0]  shift_r;
  logic [7:0]  ones_r;
  logic [3:0]  tx_div_r;
  logic        tx_bit_tick;
  logic [9:0]  tx_sh_r;
  logic [3:0]  tx_n_r;
  logic        txd_r;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_pop;
  logic [7:0]  fifo_out_data;
  logic        wr_data;
  logic        wr_push;
  logic        rd_data;
  logic [7:0]  pd_val;
  logic [7:0]  bd_val;

  // Prescaler divisor decode, used by the divider and its check.
  function automatic logic [7:0] presc_div(input logic [1:0] sel);
    case (sel)
      2'h0:    presc_div = 8'h01;
      2'h1:    presc_div = 8'h03;
      2'h2:    presc_div = 8'h04;
      default: presc_div = 8'h0D;
    endcase
  endfunction

  // Baud divisor decode: a power of two.
  function automatic logic [7:0] baud_div(input logic [2:0] sel);
    baud_div = 8'h01 << sel;
  endfunction

  assign pd_val = presc_div(baud_r[sbdb_pkg::PRESC_LSB +: 2]);    // see RULE_09
  assign bd_val = baud_div(baud_r[sbdb_pkg::BAUD_DIV_LSB +: 3]);  // see RULE_10

  // Bus handshake: a data-buffer write waits while the FIFO is full.
  assign wr_data   = ph_r.valid & ph_r.write & (ph_r.addr == sbdb_pkg::OFF_DATA_BUF);
  assign wr_push   = wr_data & fifo_in_ready;
  assign HREADYOUT = ~wr_data | fifo_in_ready;
  assign HRESP     = 1'b0;
  assign HRDATA    = hrdata_r;
  assign rd_data   = HSEL & HTRANS[1] & HREADY & ~HWRITE
                   & (HADDR[7:0] == sbdb_pkg::OFF_DATA_BUF);
  assign RX_ACTIVE = rx_act_r;
  assign TXD       = txd_r;

  // Address phase capture; reads are answered from a flop in the data phase.
  // A read right behind a write to the same register sees the old value.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ph_r     <= '0;
      hrdata_r <= 32'h0000_0000;
    end else if (HREADY) begin
      ph_r.valid <= HSEL & HTRANS[1];
      ph_r.write <= HWRITE;
      ph_r.addr  <= HADDR[7:0];
      if (HSEL & HTRANS[1] & ~HWRITE) begin
        case (HADDR[7:0])
          sbdb_pkg::OFF_DATA_BUF: hrdata_r <= {24'h00_0000, rx_data_r};  // see RULE_05
          sbdb_pkg::OFF_BAUD_SEL: hrdata_r <= {24'h00_0000, baud_r};
          sbdb_pkg::OFF_STATUS:   hrdata_r <= {29'h0000_0000, fifo_in_ready,
                                               rx_full_r, rx_act_r};  // see RULE_03
          default:                hrdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // One baud setting feeds the single divider chain; reset picks divide by 64.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      baud_r <= sbdb_pkg::BAUD_SEL_RESET;  // see RULE_12
    end else if (ph_r.valid & ph_r.write & (ph_r.addr == sbdb_pkg::OFF_BAUD_SEL)) begin
      baud_r <= HWDATA[7:0] & 8'h37;  // see RULE_08
    end
  end

  // Divider: 4*PD clocks per unit, BD units per tick, 16 ticks per bit.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pre_cnt_r <= '0;
      bd_cnt_r  <= '0;
    end else if (pre_cnt_r >= 8'(sbdb_pkg::CLK_PER_UNIT * pd_val - 1)) begin
      pre_cnt_r <= '0;
      bd_cnt_r  <= (bd_cnt_r >= 7'(bd_val - 8'h01)) ? '0 : bd_cnt_r + 7'h01;  // see RULE_11
    end else begin
      pre_cnt_r <= pre_cnt_r + 8'h01;
    end
  end
  assign tick16 = (pre_cnt_r >= 8'(sbdb_pkg::CLK_PER_UNIT * pd_val - 1))
                & (bd_cnt_r >= 7'(bd_val - 8'h01));  // see RULE_13

  // Two-flop synchroniser on the receive pin; the first flop feeds only the second.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
    end else begin
      rx_m_r <= RXD;
      rx_s_r <= rx_m_r;
    end
  end

  // Receiver sequence counted on sampling ticks.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rx_st_r <= sbdb_pkg::RX_IDLE;
      slot_r  <= '0;
      bit_r   <= '0;
    end else if (tick16) begin
      case (rx_st_r)
        sbdb_pkg::RX_IDLE: begin
          if (!rx_s_r) begin
            rx_st_r <= sbdb_pkg::RX_START;  // see RULE_13
            slot_r  <= 4'h1;
          end
        end
        sbdb_pkg::RX_START: begin
          slot_r <= slot_r + 4'h1;
          if (slot_r == 4'(sbdb_pkg::START_MID)) begin
            rx_st_r <= rx_s_r ? sbdb_pkg::RX_IDLE : sbdb_pkg::RX_DATA;
            slot_r  <= '0;
            bit_r   <= '0;
          end
        end
        sbdb_pkg::RX_DATA: begin
          slot_r <= slot_r + 4'h1;
          if (slot_r == 4'(sbdb_pkg::TICKS_PER_BIT - 1)) begin
            bit_r <= bit_r + 4'h1;
            if (bit_r == 4'(sbdb_pkg::DATA_BITS - 1)) begin
              rx_st_r <= sbdb_pkg::RX_STOP;
            end
          end
        end
        sbdb_pkg::RX_STOP: begin
          slot_r <= slot_r + 4'h1;
          if (slot_r == 4'(sbdb_pkg::TICKS_PER_BIT - 1)) begin
            rx_st_r <= sbdb_pkg::RX_IDLE;
          end
        end
        default: rx_st_r <= sbdb_pkg::RX_IDLE;
      endcase
    end
  end

  // Shift register and received byte; neither is reset so data survive reset.
  always_ff @(posedge REF_CLK) begin
    if (tick16 && rx_st_r == sbdb_pkg::RX_DATA
        && slot_r == 4'(sbdb_pkg::TICKS_PER_BIT - 1)) begin
      shift_r <= {rx_s_r, shift_r[7:1]};
    end
    if (tick16 && rx_st_r == sbdb_pkg::RX_STOP
        && slot_r == 4'(sbdb_pkg::TICKS_PER_BIT - 1)) begin
      rx_data_r <= shift_r;  // see RULE_06
    end
  end

  // Received-byte flag: a new byte wins over a read that clears it.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rx_full_r <= 1'b0;
    end else if (tick16 && rx_st_r == sbdb_pkg::RX_STOP
                 && slot_r == 4'(sbdb_pkg::TICKS_PER_BIT - 1)) begin
      rx_full_r <= 1'b1;
    end else if (rd_data) begin
      rx_full_r <= 1'b0;
    end
  end

  // Idle-line counter: high ticks seen while the receiver waits.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ones_r <= '0;
    end else if (tick16) begin
      if (rx_st_r != sbdb_pkg::RX_IDLE || !rx_s_r) begin
        ones_r <= '0;
      end else if (ones_r != 8'(sbdb_pkg::IDLE_TICKS)) begin
        ones_r <= ones_r + 8'h01;
      end
    end
  end

  // Reception-active flag: status only, so no interrupt path exists.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rx_act_r <= 1'b0;
    end else if (tick16 && rx_st_r == sbdb_pkg::RX_IDLE && !rx_s_r) begin
      rx_act_r <= 1'b1;  // see RULE_01
    end else if (tick16 && rx_st_r == sbdb_pkg::RX_START
                 && slot_r == 4'(sbdb_pkg::START_MID) && rx_s_r) begin
      rx_act_r <= 1'b0;  // see RULE_02
    end else if (ones_r == 8'(sbdb_pkg::IDLE_TICKS)) begin
      rx_act_r <= 1'b0;  // see RULE_02
    end
  end

  // Transmit FIFO between the bus and the shifter; a full FIFO stalls the bus.
  sbdb_fifo #(
    .WIDTH (8),
    .DEPTH (sbdb_pkg::FIFO_DEPTH)
  ) u_txq (
    .REF_CLK   (REF_CLK),
    .RESET     (RESET),
    .in_valid  (wr_data),
    .in_ready  (fifo_in_ready),
    .in_data   (HWDATA[7:0]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // Transmit bit tick shares the receiver's sampling tick.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      tx_div_r <= '0;
    end else if (tick16) begin
      tx_div_r <= tx_div_r + 4'h1;
    end
  end
  assign tx_bit_tick = tick16 & (tx_div_r == 4'(sbdb_pkg::TICKS_PER_BIT - 1));  // see RULE_08
  assign fifo_pop    = tx_bit_tick & (tx_st_r == sbdb_pkg::TX_IDLE) & fifo_out_valid;

  // Transmitter: start bit, eight data bits LSB first, stop bit.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      tx_st_r <= sbdb_pkg::TX_IDLE;
      tx_sh_r <= 10'h3FF;
      tx_n_r  <= '0;
      txd_r   <= 1'b1;
    end else if (tx_bit_tick) begin
      case (tx_st_r)
        sbdb_pkg::TX_IDLE: begin
          if (fifo_out_valid) begin
            tx_st_r <= sbdb_pkg::TX_SEND;
            tx_sh_r <= {1'b1, 1'b1, fifo_out_data};
            tx_n_r  <= 4'h9;
            txd_r   <= 1'b0;
          end
        end
        sbdb_pkg::TX_SEND: begin
          txd_r   <= tx_sh_r[0];
          tx_sh_r <= {1'b1, tx_sh_r[9:1]};
          tx_n_r  <= tx_n_r - 4'h1;
          if (tx_n_r == 4'h1) begin
            tx_st_r <= sbdb_pkg::TX_IDLE;
          end
        end
        default: tx_st_r <= sbdb_pkg::TX_IDLE;
      endcase
    end
  end

  // Helper: clocks since the last sampling tick.
  logic [15:0] gap_r;
  always_ff @(posedge REF_CLK) begin
    if (RESET || tick16) begin
      gap_r <= '0;
    end else begin
      gap_r <= gap_r + 16'h0001;
    end
  end

  // Helper: a whole tick period has passed with no baud write in it.
  // The first tick after a rate change may come early, so it is not judged.
  logic settle_r;
  always_ff @(posedge REF_CLK) begin
    if (RESET || (ph_r.valid & ph_r.write & (ph_r.addr == sbdb_pkg::OFF_BAUD_SEL))) begin
      settle_r <= 1'b0;
    end else if (tick16) begin
      settle_r <= 1'b1;
    end
  end

  // Checks.
  property p_set_flag;
    @(posedge REF_CLK) disable iff (RESET)
    (tick16 && rx_st_r == sbdb_pkg::RX_IDLE && !rx_s_r) |=> rx_act_r;
  endproperty
  a_set_flag: assert property (p_set_flag) else $error("flag not set on start low");  // see RULE_01

  property p_false_start;
    @(posedge REF_CLK) disable iff (RESET)
    (tick16 && rx_st_r == sbdb_pkg::RX_START && slot_r == 4'h8 && rx_s_r)
      |=> !rx_act_r && rx_st_r == sbdb_pkg::RX_IDLE;
  endproperty
  a_false_start: assert property (p_false_start) else $error("false start kept flag");  // see RULE_02

  property p_flag_rise;
    @(posedge REF_CLK) disable iff (RESET)
    $rose(rx_act_r) |-> $past(tick16) && $past(rx_st_r) == sbdb_pkg::RX_IDLE;
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag rose without start search");  // see RULE_03

  property p_read_data;
    @(posedge REF_CLK) disable iff (RESET)
    (HSEL && HTRANS[1] && HREADY && !HWRITE && HADDR[7:0] == 8'h18)
      |=> HRDATA == {24'h00_0000, $past(rx_data_r)};
  endproperty
  a_read_data: assert property (p_read_data) else $error("data buffer read mismatch");  // see RULE_05

  property p_presc;
    @(posedge REF_CLK) disable iff (RESET)
    (baud_r[5:4] == 2'h3) |-> pd_val == 8'h0D;
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler decode wrong");  // see RULE_09

  property p_bdiv;
    @(posedge REF_CLK) disable iff (RESET)
    (baud_r[2:0] == 3'h7) |-> bd_val == 8'h80;
  endproperty
  a_bdiv: assert property (p_bdiv) else $error("baud divisor decode wrong");  // see RULE_10

  property p_tick_gap;
    @(posedge REF_CLK) disable iff (RESET)
    (tick16 && settle_r)
      |-> 32'(gap_r) + 32'h1 == 32'(pd_val) * 32'(bd_val) * 32'h4;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");  // see RULE_11

  property p_reset_baud;
    @(posedge REF_CLK) $past(RESET) |-> baud_r == 8'h00;
  endproperty
  a_reset_baud: assert property (p_reset_baud) else $error("baud select not cleared");  // see RULE_12

  property p_shared_tick;
    @(posedge REF_CLK) disable iff (RESET)
    tx_bit_tick |-> tick16;
  endproperty
  a_shared_tick: assert property (p_shared_tick) else $error("tx tick off shared chain");  // see RULE_08

  c_frame: cover property (@(posedge REF_CLK) $rose(rx_full_r));
  c_false: cover property (@(posedge REF_CLK) $fell(rx_act_r) && rx_st_r == sbdb_pkg::RX_IDLE);
  c_stall: cover property (@(posedge REF_CLK) !HREADYOUT);
  c_send:  cover property (@(posedge REF_CLK) fifo_pop);
endmodule

`default_nettype wire

// ### verif/sbdb_peer.sv
// Behavioural model of the remote serial device on the far end of the link.
// Assumes the bench calls its tasks right after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none

module sbdb_peer (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);

  // The line idles high between frames.
  initial rxd = 1'b1;

  // Send one frame: start low, eight data bits LSB first, one stop high.
  task automatic send(input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (bt) @(posedge clk);
    end
  endtask

  // A short low pulse that is too brief to be a real start bit.
  task automatic glitch(input int n);
    rxd <= 1'b0;
    repeat (n) @(posedge clk);
    rxd <= 1'b1;
  endtask

  // Take one frame; the width of the start bit is measured in clocks.
  // The first data bit must be high, or the measured width runs long.
  task automatic recv(output logic [7:0] b, output int w);
    w = 0;
    while (txd !== 1'b0) @(posedge clk);
    while (txd === 1'b0) begin
      w++;
      @(posedge clk);
    end
    repeat (w / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = txd;
      repeat (w) @(posedge clk);
    end
  endtask

endmodule

`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the baud generator and data buffer block.
// Assumes one AHB-Lite master, the serial peer model and a 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module testbench;

  logic        REF_CLK;
  logic        RESET;
  logic        HSEL;
  logic [31:0] HADDR;
  logic [1:0]  HTRANS;
  logic        HWRITE;
  logic [2:0]  HSIZE;
  logic [31:0] HWDATA;
  logic [31:0] HRDATA;
  logic        HREADYOUT;
  logic        HRESP;
  logic        RXD;
  logic        TXD;
  logic        RX_ACTIVE;
  int          fail_count;
  int          cmp_count;
  logic [31:0] rv;
  logic [7:0]  got;
  logic [7:0]  tb_byte;
  int          w;
  logic [7:0]  codes [6] = '{8'h00, 8'h01, 8'h10, 8'h20, 8'h30, 8'h03};
  int          bits  [6] = '{64, 128, 192, 256, 832, 512};

  sbdb_top i_sbdb_top (
    .REF_CLK   (REF_CLK),
    .RESET     (RESET),
    .HSEL      (HSEL),
    .HADDR     (HADDR),
    .HTRANS    (HTRANS),
    .HWRITE    (HWRITE),
    .HSIZE     (HSIZE),
    .HWDATA    (HWDATA),
    .HREADY    (HREADYOUT),
    .HRDATA    (HRDATA),
    .HREADYOUT (HREADYOUT),
    .HRESP     (HRESP),
    .RXD       (RXD),
    .TXD       (TXD),
    .RX_ACTIVE (RX_ACTIVE)
  );

  sbdb_peer i_sbdb_peer (
    .clk (REF_CLK),
    .txd (TXD),
    .rxd (RXD)
  );

  // Clock with a 4 ns period.
  initial REF_CLK = 1'b0;
  always #2 REF_CLK = ~REF_CLK;

  // Count every compare and report a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single AHB-Lite transfer; the wait on HREADYOUT is unbounded here,
  // so the watchdog alone ends a stuck slave.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    HSEL   <= 1'b1;
    HTRANS <= 2'b10;
    HADDR  <= {24'h000000, a};
    HWRITE <= wr;
    HSIZE  <= 3'b010;
    @(posedge REF_CLK);
    while (HREADYOUT !== 1'b1) @(posedge REF_CLK);
    HSEL   <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    @(posedge REF_CLK);
    while (HREADYOUT !== 1'b1) @(posedge REF_CLK);
    rv = HRDATA;
  endtask

  // Print the verdict and stop.
  task automatic tally_and_finish();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // The longest test is the slow rate loop; this limit leaves ample margin.
  initial begin
    repeat (95000) @(posedge REF_CLK);
    fail_count++;
    tally_and_finish();
  end

  // Main sequence of tests.
  initial begin
    RESET      = 1'b1;
    HSEL       = 1'b0;
    HADDR      = 32'h00000000;
    HTRANS     = 2'b00;
    HWRITE     = 1'b0;
    HSIZE      = 3'b010;
    HWDATA     = 32'h00000000;
    fail_count = 0;
    cmp_count  = 0;
    repeat (12) @(posedge REF_CLK);
    RESET <= 1'b0;
    @(posedge REF_CLK);
    ahb(1'b0, sbdb_pkg::OFF_BAUD_SEL, 32'h0);
    chk(rv, 32'h00000000);
    ahb(1'b0, sbdb_pkg::OFF_STATUS, 32'h0);
    chk(rv, 32'h00000004);
    chk({30'h0, TXD, RX_ACTIVE}, 32'h00000002);
    ahb(1'b1, sbdb_pkg::OFF_STATUS, 32'hFFFFFFFF);
    ahb(1'b0, sbdb_pkg::OFF_STATUS, 32'h0);
    chk(rv, 32'h00000004);
    ahb(1'b1, 8'h40, 32'hFFFFFFFF);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rv, 32'h00000000);
    ahb(1'b1, sbdb_pkg::OFF_BAUD_SEL, 32'hFFFFFFFF);
    ahb(1'b0, sbdb_pkg::OFF_BAUD_SEL, 32'h0);
    chk(rv, 32'h00000037);
    // Each rate is used to send and to receive; the first data bit is high
    // so the start bit alone sets the measured bit width.
    for (int k = 0; k < 6; k++) begin
      tb_byte = 8'hA5 ^ {codes[k][6:0], 1'b0};
      ahb(1'b1, sbdb_pkg::OFF_BAUD_SEL, {24'h0, codes[k]});
      fork
        ahb(1'b1, sbdb_pkg::OFF_DATA_BUF, {24'h0, tb_byte});
        i_sbdb_peer.recv(got, w);
      join
      chk({24'h0, got}, {24'h0, tb_byte});
      chk(32'(w), 32'(bits[k]));
      fork
        i_sbdb_peer.send(~tb_byte, bits[k]);
        begin
          repeat (bits[k] / 4) @(posedge REF_CLK);
          chk({31'h0, RX_ACTIVE}, 32'h1);
        end
      join
      ahb(1'b0, sbdb_pkg::OFF_DATA_BUF, 32'h0);
      chk(rv, {24'h0, ~tb_byte});
    end
    // Flag stays up after a frame until a full idle character has passed.
    ahb(1'b1, sbdb_pkg::OFF_BAUD_SEL, 32'h0);
    i_sbdb_peer.send(8'h5A, 64);
    repeat (500) @(posedge REF_CLK);
    chk({31'h0, RX_ACTIVE}, 32'h1);
    repeat (220) @(posedge REF_CLK);
    chk({31'h0, RX_ACTIVE}, 32'h0);
    // A low shorter than half a bit is rejected as a false start.
    i_sbdb_peer.glitch(12);
    chk({31'h0, RX_ACTIVE}, 32'h1);
    repeat (48) @(posedge REF_CLK);
    chk({31'h0, RX_ACTIVE}, 32'h0);
    // The byte from the idle test is still unread, so the full bit stands.
    ahb(1'b0, sbdb_pkg::OFF_STATUS, 32'h0);
    chk(rv, 32'h00000006);
    // Fill the transmit path until it refuses, then drain it in order.
    // The data buffer only ever sees plain writes here, never a read-back.
    fork
      begin
        for (int j = 0; j < 5; j++) ahb(1'b1, sbdb_pkg::OFF_DATA_BUF, 32'(8'h11 + 8'h10 * j));
        ahb(1'b0, sbdb_pkg::OFF_STATUS, 32'h0);
        chk(rv, 32'h00000002);
        ahb(1'b1, sbdb_pkg::OFF_DATA_BUF, 32'h00000061);
      end
      for (int j = 0; j < 6; j++) begin
        i_sbdb_peer.recv(got, w);
        chk({24'h0, got}, 32'(8'h11 + 8'h10 * j));
      end
    join
    // Software waits for the flag to drop before it resets the block.
    i_sbdb_peer.send(8'h96, 64);
    for (int i = 0; i < 1000 && RX_ACTIVE !== 1'b0; i++) @(posedge REF_CLK);
    chk({31'h0, RX_ACTIVE}, 32'h0);
    ahb(1'b1, sbdb_pkg::OFF_BAUD_SEL, 32'h00000021);
    RESET <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    RESET <= 1'b0;
    @(posedge REF_CLK);
    ahb(1'b0, sbdb_pkg::OFF_DATA_BUF, 32'h0);
    chk(rv, 32'h00000096);
    ahb(1'b0, sbdb_pkg::OFF_BAUD_SEL, 32'h0);
    chk(rv, 32'h00000000);
    tally_and_finish();
  end

endmodule

`default_nettype wire
